// File: shared/pist_params.svh
/*
 Offsets, field positions and reset values of the interrupt status tree.
 Assumes inclusion by bare name from design files.
*/
`ifndef PIST_PARAMS_SVH
`define PIST_PARAMS_SVH

// printed offsets are not all multiples of four: they are indices
`define PIST_IDX_TOP         8'h5A
`define PIST_IDX_REGSUM      8'h5B
`define PIST_IDX_PAIRA       8'h5C
`define PIST_IDX_GRPIN       8'h60
`define PIST_RESET_BYTE      8'h00
`define PIST_BIT_FSM         7
`define PIST_BIT_SEVERE      6
`define PIST_BIT_MODERATE    5
`define PIST_BIT_MISC        4
`define PIST_BIT_STARTUP     3
`define PIST_BIT_GPIO        2
`define PIST_BIT_VMON        1
`define PIST_BIT_REG         0
`define PIST_BIT_PAIRB       1
`define PIST_BIT_PAIRA       0
`define PIST_FLAGS           8

`endif

// File: shared/pist_pkg.sv
/*
 Types of the interrupt status tree.
 Assumes the params header is compiled alongside.
*/
`default_nettype none
package pist_pkg;
	typedef struct packed {
		logic [7:0] fsmErr;
		logic [7:0] severeErr;
		logic [7:0] moderateErr;
		logic [7:0] misc;
		logic [7:0] startup;
		logic [7:0] gpio;
		logic [7:0] vmon;
		logic [7:0] pairB;
	} pist_groups_t;

	// one pulse per fault; bit layout matches the pair register
	typedef struct packed {
		logic [7:0] events;
	} pist_pair_evt_t;

	typedef enum logic [1:0] {
		PIST_W_IDLE = 2'b00,
		PIST_W_RESP = 2'b01
	} pist_wstate_t;

	typedef enum logic [0:0] {
		PIST_R_IDLE = 1'b0,
		PIST_R_DATA = 1'b1
	} pist_rstate_t;
endpackage
`default_nettype wire

// File: hw/pist_flag_bank.sv
/*
 Bank of latched write-one-to-clear flags.
 Assumes events and the clear strobe are on clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pist_params.svh"
module pist_flag_bank
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic [7:0]  setPulse,
	input  wire logic        clrStrobe,
	input  wire logic [7:0]  clrMask,
	output logic      [7:0]  flags
);
	typedef struct packed {
		logic [7:0] flags;
	} pist_bank_state_t;

	pist_bank_state_t state_q;
	pist_bank_state_t state_d;
	logic [7:0]       nxtFlags;

	genvar i;

	// set after clear so a fresh fault is never lost
	generate
		for (i = 0; i < `PIST_FLAGS; i++)
		begin : g_flag
			assign nxtFlags[i] = setPulse[i] | (state_q.flags[i] & ~(clrStrobe & clrMask[i]));
		end
	endgenerate

	always_comb
	begin
		state_d = state_q;
		state_d.flags = nxtFlags;
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
			state_q <= '0;
		else
			state_q <= state_d;
	end

	assign flags = state_q.flags;

	a_set_wins: assert property (@(posedge clk) disable iff (!nrst)
		(setPulse != 8'h00) |=> ((flags & $past(setPulse)) == $past(setPulse)))
		else $error("fault event lost");
	a_clear_one: assert property (@(posedge clk) disable iff (!nrst)
		(clrStrobe && (setPulse == 8'h00)) |=> ((flags & $past(clrMask)) == 8'h00))
		else $error("write one did not clear flag");
	a_flag_holds: assert property (@(posedge clk) disable iff (!nrst)
		(!clrStrobe) |=> ((flags & $past(flags)) == $past(flags)))
		else $error("flag dropped without clear");
endmodule
`default_nettype wire

// File: hw/pist_status_tree.sv
/*
 Hierarchical interrupt status tree behind an AXI4-Lite slave.
 Assumes group registers outside feed their current contents on groups,
 and fault events arrive as one-cycle pulses on clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pist_params.svh"
// What this block does
// - top bit 7 mirrors state machine errors
// - top bit 6 mirrors severe error group
// - top bit 5 mirrors moderate error group
// - top bit 4 mirrors miscellaneous group
// - top bit 3 mirrors startup group
// - top bit 2 mirrors pin event group
// - top bit 1 mirrors voltage monitor group
// - top bit 0 mirrors regulator summary
// - regulator summary bit 1 mirrors pair B
// - regulator summary bit 0 mirrors pair A
// - bit 7 latches regulator 2 current limit
// - bit 6 latches regulator 2 short circuit
// - bit 5 latches regulator 2 undervoltage
// - bit 4 latches regulator 2 overvoltage
// - bit 3 latches regulator 1 current limit
// - bit 2 latches regulator 1 short circuit
// - bit 1 latches regulator 1 undervoltage
// - bit 0 latches regulator 1 overvoltage
module pist_status_tree
(
	input  wire logic                  clk,
	input  wire logic                  nrst,
	input  wire pist_pkg::pist_groups_t groups,
	input  wire pist_pkg::pist_pair_evt_t pairEvt,
	input  wire logic [11:0]           s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [11:0]           s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	output logic [7:0]                 topSummary,
	output logic [7:0]                 regulatorSummary
);
	typedef struct packed {
		pist_pkg::pist_wstate_t wst;
		logic        awHave;
		logic [11:0] awAddr;
		logic        wHave;
		logic [7:0]  wData;
		logic        wLane0;
		logic        awReady;
		logic        wReady;
		logic        bValid;
		logic [1:0]  bResp;
		pist_pkg::pist_rstate_t rst;
		logic        arReady;
		logic        rValid;
		logic [31:0] rData;
		logic [1:0]  rResp;
		logic [7:0]  top;
		logic [7:0]  regSum;
	} pist_state_t;

	pist_state_t state_q;
	pist_state_t state_d;

	logic [7:0] pairA;
	logic       clrStrobe;
	logic [7:0] clrMask;
	logic [7:0] regSumNow;
	logic [7:0] topNow;

	// word address to register index, shared by read and write paths
	// limitation: address bits above the index are ignored, so registers alias
	function automatic logic [7:0] regIndex(input logic [11:0] addr);
		regIndex = addr[9:2];
	endfunction

	function automatic logic known(input logic [11:0] addr);
		logic [7:0] idx;
		idx = regIndex(addr);
		known = (idx == `PIST_IDX_TOP) || (idx == `PIST_IDX_REGSUM) || (idx == `PIST_IDX_PAIRA);
	endfunction

	pist_flag_bank u_pairA
	(
		.clk       (clk),
		.nrst      (nrst),
		.setPulse  (pairEvt.events),
		.clrStrobe (clrStrobe),
		.clrMask   (clrMask),
		.flags     (pairA)
	);

	always_comb
	begin
		regSumNow = 8'h00;
		regSumNow[`PIST_BIT_PAIRB] = |groups.pairB;
		regSumNow[`PIST_BIT_PAIRA] = |pairA;
		topNow = 8'h00;
		topNow[`PIST_BIT_FSM]      = |groups.fsmErr;
		topNow[`PIST_BIT_SEVERE]   = |groups.severeErr;
		topNow[`PIST_BIT_MODERATE] = |groups.moderateErr;
		topNow[`PIST_BIT_MISC]     = |groups.misc;
		topNow[`PIST_BIT_STARTUP]  = |groups.startup;
		topNow[`PIST_BIT_GPIO]     = |groups.gpio;
		topNow[`PIST_BIT_VMON]     = |groups.vmon;
		topNow[`PIST_BIT_REG]      = |regSumNow;
	end

	// a clear is a write of lane 0 to the pair register; zeros clear nothing
	assign clrStrobe = (state_q.wst == pist_pkg::PIST_W_IDLE) && state_q.awHave && state_q.wHave
		&& state_q.wLane0 && (regIndex(state_q.awAddr) == `PIST_IDX_PAIRA);
	assign clrMask = state_q.wData;

	always_comb
	begin
		state_d = state_q;
		state_d.top = topNow;
		state_d.regSum = regSumNow;
		state_d.awReady = 1'b0;
		state_d.wReady = 1'b0;
		state_d.arReady = 1'b0;
		// write: collect address and data in either order
		case (state_q.wst)
			pist_pkg::PIST_W_IDLE:
			begin
				if (state_q.awHave && state_q.wHave)
				begin
					state_d.bValid = 1'b1;
					state_d.bResp = known(state_q.awAddr) ? 2'b00 : 2'b10;
					state_d.wst = pist_pkg::PIST_W_RESP;
				end
				else
				begin
					if (s_axi_awvalid && state_q.awReady)
					begin
						state_d.awHave = 1'b1;
						state_d.awAddr = s_axi_awaddr;
					end
					else if (!state_q.awHave && !state_q.awReady)
						state_d.awReady = 1'b1;
					if (s_axi_wvalid && state_q.wReady)
					begin
						state_d.wHave = 1'b1;
						state_d.wData = s_axi_wdata[7:0];
						state_d.wLane0 = s_axi_wstrb[0];
					end
					else if (!state_q.wHave && !state_q.wReady)
						state_d.wReady = 1'b1;
				end
			end
			pist_pkg::PIST_W_RESP:
			begin
				if (s_axi_bready)
				begin
					state_d.bValid = 1'b0;
					state_d.awHave = 1'b0;
					state_d.wHave = 1'b0;
					state_d.wst = pist_pkg::PIST_W_IDLE;
				end
			end
			default:
			begin
				state_d.wst = pist_pkg::PIST_W_IDLE;
			end
		endcase
		// read: reserved and upper bits read zero
		case (state_q.rst)
			pist_pkg::PIST_R_IDLE:
			begin
				if (s_axi_arvalid && state_q.arReady)
				begin
					state_d.rValid = 1'b1;
					state_d.rResp = 2'b00;
					state_d.rData = 32'h0000_0000;
					case (regIndex(s_axi_araddr))
						`PIST_IDX_TOP:    state_d.rData[7:0] = state_q.top;
						`PIST_IDX_REGSUM: state_d.rData[7:0] = state_q.regSum;
						`PIST_IDX_PAIRA:  state_d.rData[7:0] = pairA;
						default:          state_d.rResp = 2'b10;
					endcase
					state_d.rst = pist_pkg::PIST_R_DATA;
				end
				else
					state_d.arReady = !state_q.arReady;
			end
			pist_pkg::PIST_R_DATA:
			begin
				if (s_axi_rready)
				begin
					state_d.rValid = 1'b0;
					state_d.rst = pist_pkg::PIST_R_IDLE;
				end
			end
			default:
			begin
				state_d.rst = pist_pkg::PIST_R_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			state_q <= '0;
		end
		else
		begin
			state_q <= state_d;
		end
	end

	assign s_axi_awready    = state_q.awReady;
	assign s_axi_wready     = state_q.wReady;
	assign s_axi_bvalid     = state_q.bValid;
	assign s_axi_bresp      = state_q.bResp;
	assign s_axi_arready    = state_q.arReady;
	assign s_axi_rvalid     = state_q.rValid;
	assign s_axi_rdata      = state_q.rData;
	assign s_axi_rresp      = state_q.rResp;
	assign topSummary       = state_q.top;
	assign regulatorSummary = state_q.regSum;

	sequence s_groupsQuiet;
		(groups.fsmErr == 8'h00) && (groups.severeErr == 8'h00);
	endsequence

	// a write with both beats held and not yet answered
	sequence s_idleWrite;
		(state_q.wst == pist_pkg::PIST_W_IDLE) && state_q.awHave && state_q.wHave;
	endsequence

	sequence s_noClearWrite;
		s_idleWrite ##0 !(state_q.wLane0 && (regIndex(state_q.awAddr) == `PIST_IDX_PAIRA));
	endsequence

	sequence s_pairClear;
		clrStrobe && (pairEvt.events == 8'h00);
	endsequence

	sequence s_readTop;
		s_axi_arvalid && s_axi_arready && (regIndex(s_axi_araddr) == `PIST_IDX_TOP);
	endsequence

	sequence s_readRegSum;
		s_axi_arvalid && s_axi_arready && (regIndex(s_axi_araddr) == `PIST_IDX_REGSUM);
	endsequence

	sequence s_readPair;
		s_axi_arvalid && s_axi_arready && (regIndex(s_axi_araddr) == `PIST_IDX_PAIRA);
	endsequence

	a_top_fsm: assert property (@(posedge clk) disable iff (!nrst)
		##1 (topSummary[7] == $past(|groups.fsmErr)))
		else $error("top bit 7 wrong");
	a_top_severe: assert property (@(posedge clk) disable iff (!nrst)
		(groups.severeErr != 8'h00) |=> topSummary[6])
		else $error("top bit 6 not set");
	a_top_clear: assert property (@(posedge clk) disable iff (!nrst)
		s_groupsQuiet ##1 s_groupsQuiet |=> (topSummary[7:6] == 2'b00))
		else $error("top error bits did not clear");
	a_top_mid: assert property (@(posedge clk) disable iff (!nrst)
		##1 (topSummary[5:1] == $past({|groups.moderateErr, |groups.misc, |groups.startup,
		|groups.gpio, |groups.vmon})))
		else $error("top bits 5 to 1 wrong");
	a_top_reg: assert property (@(posedge clk) disable iff (!nrst)
		##1 (topSummary[0] == $past((groups.pairB != 8'h00) || (pairA != 8'h00))))
		else $error("top bit 0 wrong");
	a_regsum_pairs: assert property (@(posedge clk) disable iff (!nrst)
		##1 (regulatorSummary == {6'h00, $past(|groups.pairB), $past(|pairA)}))
		else $error("regulator summary wrong");
	a_resp_both: assert property (@(posedge clk) disable iff (!nrst)
		$rose(s_axi_bvalid) |-> $past(state_q.awHave && state_q.wHave))
		else $error("write answered early");
	a_read_answer: assert property (@(posedge clk) disable iff (!nrst)
		(s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
		else $error("read not answered");
	a_top_misc: assert property (@(posedge clk) disable iff (!nrst)
		##1 (topSummary[4] == $past(groups.misc != 8'h00)))
		else $error("top bit 4 wrong");
	a_top_startup: assert property (@(posedge clk) disable iff (!nrst)
		##1 (topSummary[3] == $past(groups.startup != 8'h00)))
		else $error("top bit 3 wrong");
	a_top_gpio: assert property (@(posedge clk) disable iff (!nrst)
		##1 (topSummary[2] == $past(groups.gpio != 8'h00)))
		else $error("top bit 2 wrong");
	a_top_vmon: assert property (@(posedge clk) disable iff (!nrst)
		##1 (topSummary[1] == $past(groups.vmon != 8'h00)))
		else $error("top bit 1 wrong");
	a_top_severe_clr: assert property (@(posedge clk) disable iff (!nrst)
		(groups.severeErr == 8'h00) |=> !topSummary[6])
		else $error("top bit 6 did not clear");
	a_top_reg_link: assert property (@(posedge clk) disable iff (!nrst)
		(topSummary[0] == (regulatorSummary != 8'h00)))
		else $error("top bit 0 disagrees with regulator summary");
	a_regsum_pairb: assert property (@(posedge clk) disable iff (!nrst)
		##1 (regulatorSummary[1] == $past(groups.pairB != 8'h00)))
		else $error("regulator summary bit 1 wrong");
	a_regsum_rsvd: assert property (@(posedge clk) disable iff (!nrst)
		(regulatorSummary[7:2] == 6'h00))
		else $error("reserved summary bits not zero");
	a_pair_set: assert property (@(posedge clk) disable iff (!nrst)
		(pairEvt.events != 8'h00) |=> ((pairA & $past(pairEvt.events)) == $past(pairEvt.events)))
		else $error("pair flag did not latch");
	a_pair_clear: assert property (@(posedge clk) disable iff (!nrst)
		s_pairClear |=> ((pairA & $past(clrMask)) == 8'h00))
		else $error("pair flag not cleared by write one");
	a_pair_keep: assert property (@(posedge clk) disable iff (!nrst)
		s_noClearWrite |=> ((pairA & $past(pairA)) == $past(pairA)))
		else $error("pair flag changed by a write that clears nothing");
	a_rdata_top: assert property (@(posedge clk) disable iff (!nrst)
		s_readTop |=> (s_axi_rdata == {24'h000000, $past(topSummary)}))
		else $error("top summary read wrong");
	a_rdata_regsum: assert property (@(posedge clk) disable iff (!nrst)
		s_readRegSum |=> (s_axi_rdata == {24'h000000, $past(regulatorSummary)}))
		else $error("regulator summary read wrong");
	a_rdata_pair: assert property (@(posedge clk) disable iff (!nrst)
		s_readPair |=> (s_axi_rdata == {24'h000000, $past(pairA)}))
		else $error("pair register read wrong");
	a_rdata_upper: assert property (@(posedge clk) disable iff (!nrst)
		s_axi_rvalid |-> (s_axi_rdata[31:8] == 24'h000000))
		else $error("upper read bits not zero");
	a_write_answer: assert property (@(posedge clk) disable iff (!nrst)
		s_idleWrite |=> s_axi_bvalid)
		else $error("write not answered");
	a_bvalid_drop: assert property (@(posedge clk) disable iff (!nrst)
		(s_axi_bvalid && s_axi_bready) |=> !s_axi_bvalid)
		else $error("write response held after handshake");
	a_rvalid_drop: assert property (@(posedge clk) disable iff (!nrst)
		(s_axi_rvalid && s_axi_rready) |=> !s_axi_rvalid)
		else $error("read response held after handshake");
endmodule
`default_nettype wire

// File: tb/tb_pist_status_tree.sv
/*
 Self-checking bench for the interrupt status tree: group summaries, pair A flags, AXI4-Lite access.
 Assumes the params header and package are compiled first; no partner model, bench drives every port.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pist_params.svh"
module tb_pist_status_tree;
	logic                     clk;
	logic                     nrst;
	pist_pkg::pist_groups_t   groups;
	pist_pkg::pist_pair_evt_t pairEvt;
	logic [11:0]              s_axi_awaddr;
	logic                     s_axi_awvalid;
	logic                     s_axi_awready;
	logic [31:0]              s_axi_wdata;
	logic [3:0]               s_axi_wstrb;
	logic                     s_axi_wvalid;
	logic                     s_axi_wready;
	logic [1:0]               s_axi_bresp;
	logic                     s_axi_bvalid;
	logic                     s_axi_bready;
	logic [11:0]              s_axi_araddr;
	logic                     s_axi_arvalid;
	logic                     s_axi_arready;
	logic [31:0]              s_axi_rdata;
	logic [1:0]               s_axi_rresp;
	logic                     s_axi_rvalid;
	logic                     s_axi_rready;
	logic [7:0]               topSummary;
	logic [7:0]               regulatorSummary;
	int                       mismatches;
	int                       n_compared;
	int                       cycles;

	pist_status_tree dut (.clk(clk), .nrst(nrst), .groups(groups), .pairEvt(pairEvt),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .topSummary(topSummary),
		.regulatorSummary(regulatorSummary));

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic stop_test();
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// whole run needs about 500 cycles
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			mismatches++;
			stop_test();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
			mismatches++;
		end
	endtask

	function automatic logic [11:0] ba(input logic [7:0] idx);
		return {2'b00, idx, 2'b00};
	endfunction

	// evt is pulsed so that it lands on the same edge as the clear
	task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] s, input logic [7:0] evt,
		input logic [1:0] expResp);
		int n;
		logic pend;
		logic still;
		n = 0;
		s_axi_awaddr <= ba(idx);
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= {24'h000000, d};
		s_axi_wstrb <= s;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (n < 40)
		begin
			@(posedge clk);
			n++;
			pend = s_axi_awvalid | s_axi_wvalid;
			still = (s_axi_awvalid & ~s_axi_awready) | (s_axi_wvalid & ~s_axi_wready);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			pairEvt.events <= (pend & ~still) ? evt : 8'h00;
			if (s_axi_bvalid & ~pend)
			begin
				chk("bresp", {30'h0, expResp}, {30'h0, s_axi_bresp});
				s_axi_bready <= 1'b0;
				n = 99;
			end
		end
		if (n != 99)
			chk("write done", 32'h1, 32'h0);
		// one edge apart so the next call never reassigns bready in this step
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] expResp);
		int n;
		n = 0;
		s_axi_araddr <= ba(idx);
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (n < 40)
		begin
			@(posedge clk);
			n++;
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid & ~s_axi_arvalid)
			begin
				chk("rdata", {24'h0, exp}, s_axi_rdata);
				chk("rresp", {30'h0, expResp}, {30'h0, s_axi_rresp});
				s_axi_rready <= 1'b0;
				n = 99;
			end
		end
		if (n != 99)
			chk("read done", 32'h1, 32'h0);
		@(posedge clk);
	endtask

	task automatic pulse(input logic [7:0] e);
		@(posedge clk);
		pairEvt.events <= e;
		@(posedge clk);
		pairEvt.events <= 8'h00;
		repeat (3) @(posedge clk);
	endtask

	task automatic t_reset();
		chk("top out", 32'h0, {24'h0, topSummary});
		chk("regsum out", 32'h0, {24'h0, regulatorSummary});
		rd(`PIST_IDX_TOP, `PIST_RESET_BYTE, 2'b00);
		rd(`PIST_IDX_REGSUM, `PIST_RESET_BYTE, 2'b00);
		rd(`PIST_IDX_PAIRA, `PIST_RESET_BYTE, 2'b00);
		rd(8'h00, 8'h00, 2'b10);
		wr(8'h00, 8'hFF, 4'hF, 8'h00, 2'b10);
	endtask

	// one group at a time: its summary bit follows it up and back down
	task automatic t_groups();
		logic [7:0] expTop;
		logic [7:0] expReg;
		for (int i = 0; i < 8; i++)
		begin
			expTop = (i < 7) ? (8'h01 << (7 - i)) : 8'h01;
			expReg = (i < 7) ? 8'h00 : 8'h02;
			@(posedge clk);
			groups <= pist_pkg::pist_groups_t'(64'h0000000000000080 << (8 * (7 - i)));
			repeat (4) @(posedge clk);
			chk("top out", {24'h0, expTop}, {24'h0, topSummary});
			chk("regsum out", {24'h0, expReg}, {24'h0, regulatorSummary});
			wr(`PIST_IDX_TOP, 8'h00, 4'hF, 8'h00, 2'b00);
			wr(`PIST_IDX_REGSUM, 8'hFF, 4'hF, 8'h00, 2'b00);
			rd(`PIST_IDX_TOP, expTop, 2'b00);
			rd(`PIST_IDX_REGSUM, expReg, 2'b00);
			groups <= '0;
			repeat (4) @(posedge clk);
			chk("top cleared", 32'h0, {24'h0, topSummary});
			chk("regsum cleared", 32'h0, {24'h0, regulatorSummary});
		end
	endtask

	task automatic t_flags();
		logic [7:0] m;
		for (int b = 0; b < `PIST_FLAGS; b++)
		begin
			m = 8'h01 << b;
			pulse(m);
			repeat (3) @(posedge clk);
			chk("regsum out", 32'h1, {24'h0, regulatorSummary});
			chk("top out", 32'h1, {24'h0, topSummary});
			wr(`PIST_IDX_PAIRA, ~m, 4'hF, 8'h00, 2'b00);
			wr(`PIST_IDX_PAIRA, m, 4'h0, 8'h00, 2'b00);
			rd(`PIST_IDX_PAIRA, m, 2'b00);
			wr(`PIST_IDX_PAIRA, m, 4'h1, 8'h00, 2'b00);
			rd(`PIST_IDX_PAIRA, 8'h00, 2'b00);
			repeat (3) @(posedge clk);
			chk("regsum cleared", 32'h0, {24'h0, regulatorSummary});
			chk("top cleared", 32'h0, {24'h0, topSummary});
		end
	endtask

	// a fault that coincides with its own clear must survive
	task automatic t_collide();
		pulse(8'h48);
		wr(`PIST_IDX_PAIRA, 8'h48, 4'h1, 8'h08, 2'b00);
		repeat (2) @(posedge clk);
		rd(`PIST_IDX_PAIRA, 8'h08, 2'b00);
		wr(`PIST_IDX_PAIRA, 8'h08, 4'h1, 8'h00, 2'b00);
		rd(`PIST_IDX_PAIRA, 8'h00, 2'b00);
	endtask

	initial
	begin
		mismatches = 0;
		n_compared = 0;
		nrst = 1'b0;
		groups = '0;
		pairEvt = '0;
		s_axi_awaddr = 12'h000;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = 32'h00000000;
		s_axi_wstrb = 4'h0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_araddr = 12'h000;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
		t_reset();
		t_groups();
		t_flags();
		t_collide();
		stop_test();
	end
endmodule
`default_nettype wire
